// ==== ccl_pkg.sv ====
package ccl_pkg;

   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [13:0] IDX_THR_LO = 14'h0D00;
   localparam logic [13:0] IDX_THR_HI = 14'h0D01;
   localparam logic [13:0] IDX_FILL = 14'h0D02;
   localparam logic [13:0] IDX_DRAIN = 14'h0D03;
   localparam logic [13:0] IDX_STAB_LO = 14'h0D04;
   localparam logic [13:0] IDX_STAB_HI = 14'h0D05;
   localparam logic [13:0] IDX_PRI_CTRL = 14'h0D10;
   localparam logic [13:0] IDX_SEC_CTRL = 14'h0D20;
   localparam logic [13:0] IDX_STATUS = 14'h0D40;
   localparam logic [13:0] IDX_PRI_PER_LO = 14'h0D50;
   localparam logic [13:0] IDX_PRI_PER_HI = 14'h0D51;
   localparam logic [13:0] IDX_SEC_PER_LO = 14'h0D52;
   localparam logic [13:0] IDX_SEC_PER_HI = 14'h0D53;
   localparam logic [13:0] IDX_LOOP_BW = 14'h0D54;
   localparam logic [13:0] IDX_LEG_SEL = 14'h0D55;
   localparam logic [13:0] IDX_LEG_STATUS = 14'h3002;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int CTRL_EN_BIT = 7;
   localparam logic [7:0] CTRL_RST = 8'h31;
   localparam logic [5:0] SEL_NULL = 6'h31;
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_LEG_REF_BIT = 2;
   localparam int ST_ACT_REF_BIT = 3;
   localparam int ST_V0_BIT = 4;
   localparam int ST_V1_BIT = 5;
   localparam logic [15:0] PER_RST = 16'h0100;
   localparam logic [7:0] BW_RST = 8'h00;
   localparam logic [4:0] LEG_SEL_RST = 5'h00;
   localparam logic [15:0] LOCK_ACC_MAX = 16'h0FFF;
   localparam logic [15:0] VAL_DELAY_MS = 16'h000A;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_PRI = 2'b01,
      SW_SEC = 2'b10
   } ccl_sw_state_t;

   typedef struct packed {
      logic [15:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [15:0] araddr;
      logic arvalid;
      logic rready;
   } ccl_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } ccl_axil_rsp_t;

endpackage : ccl_pkg

// ==== ccl_ref_lock.sv ====
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// - Two time stamp references: primary, secondary
// - Slot control bit 7 enables, resets 0
// - Clearing active enable forces switchover
// - Five-bit source select; bits 5:0 at 0x31 mean none
// - Primary select overrides legacy select
// - Valid while period within 3.125 percent
// - Invalid on two-period timeout or disable
// - Secondary monitor adds validation delay
// - Status bits 4,5 show reference validity
// - Validity transitions feed interrupt events
// - Legacy reference status bit is undefined
// - Programmable detector only when threshold nonzero
// - Threshold, fill, drain at their registers
// - Stability timer delays locked indication
// - Timer is 16-bit milliseconds at 0x0D04
// - Zero timer reports lock without delay
// - Lock mirrored in both status bit 1
// - Loop filter bandwidth shared with aux loop
// - Nonrevertive: keep reference until invalid
// - Validation delay only while primary invalid
// - Status bit 3 shows active reference
// - Status bit 0 shows loop active
module ccl_ref_lock #(
   parameter int MS_TICK_CYCLES = ccl_pkg::MS_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire ccl_pkg::ccl_axil_req_t axil_req_i,
   output ccl_pkg::ccl_axil_rsp_t axil_rsp_o,
   input wire logic [31:0] ts_event_i,
   input wire logic [15:0] phase_err_i,
   input wire logic phase_err_valid_i,
   input wire logic legacy_lock_i,
   output logic [4:0] ref_src_sel_o,
   output logic loop_active_o,
   output logic locked_o,
   output logic [1:0] ref_valid_o,
   output logic [3:0] ref_event_o,
   output logic [7:0] loop_bw_o
);
   import ccl_pkg::*;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Window of one 32nd around the expected period
   function automatic logic period_ok(input logic [17:0] meas, input logic [15:0] exp_per);
      logic [17:0] e;
      logic [17:0] tol;
      e = {2'b00, exp_per};
      tol = {7'h00, exp_per[15:5]};
      period_ok = (meas >= e - tol) && (meas <= e + tol);
   endfunction : period_ok

   function automatic logic slot_null(input logic [7:0] ctrl);
      slot_null = (ctrl[5:0] == SEL_NULL);
   endfunction : slot_null

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] thr;
   logic [7:0] fill;
   logic [7:0] drain;
   logic [15:0] stab_ms;
   logic [7:0] pri_ctrl;
   logic [7:0] sec_ctrl;
   logic [15:0] pri_per;
   logic [15:0] sec_per;
   logic [7:0] loop_bw;
   logic [4:0] leg_sel;

   logic aw_got;
   logic w_got;
   logic [13:0] aw_idx;
   logic [7:0] w_byte;
   logic w_lane0;
   logic awready;
   logic wready;
   logic bvalid;
   logic [1:0] bresp;
   logic arready;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;

   logic [1:0] vld;
   ccl_sw_state_t sw_state;
   logic pd_lock;
   logic locked;
   logic [7:0] status_byte;
   logic [7:0] leg_status;

   // ----------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------
   logic do_wr;
   logic wr_hit;
   assign do_wr = aw_got && w_got && !bvalid;

   // Address and data taken in either order, held until the write
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_idx <= 14'h0000;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
      end
      else
      begin
         if (awready && axil_req_i.awvalid)
         begin
            aw_got <= 1'b1;
            aw_idx <= axil_req_i.awaddr[15:2];
            awready <= 1'b0;
         end
         if (wready && axil_req_i.wvalid)
         begin
            w_got <= 1'b1;
            w_byte <= axil_req_i.wdata[7:0];
            w_lane0 <= axil_req_i.wstrb[0];
            wready <= 1'b0;
         end
         if (do_wr)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
         end
         if (bvalid && axil_req_i.bready)
         begin
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Decode of mapped indices, status included; status indices are read only
   always_comb
   begin
      case (aw_idx)
         IDX_THR_LO, IDX_THR_HI, IDX_FILL, IDX_DRAIN, IDX_STAB_LO, IDX_STAB_HI,
         IDX_PRI_CTRL, IDX_SEC_CTRL, IDX_PRI_PER_LO, IDX_PRI_PER_HI,
         IDX_SEC_PER_LO, IDX_SEC_PER_HI, IDX_LOOP_BW, IDX_LEG_SEL,
         IDX_STATUS, IDX_LEG_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response: unmapped index answers SLVERR
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && axil_req_i.bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // Register storage; byte lane 0 carries each byte register
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         thr <= 16'h0000;
         fill <= 8'h00;
         drain <= 8'h00;
         stab_ms <= 16'h0000;
         pri_ctrl <= CTRL_RST;
         sec_ctrl <= CTRL_RST;
         pri_per <= PER_RST;
         sec_per <= PER_RST;
         loop_bw <= BW_RST;
         leg_sel <= LEG_SEL_RST;
      end
      else if (do_wr && w_lane0)
      begin
         case (aw_idx)
            IDX_THR_LO: thr[7:0] <= w_byte;
            IDX_THR_HI: thr[15:8] <= w_byte;
            IDX_FILL: fill <= w_byte;
            IDX_DRAIN: drain <= w_byte;
            IDX_STAB_LO: stab_ms[7:0] <= w_byte;
            IDX_STAB_HI: stab_ms[15:8] <= w_byte;
            IDX_PRI_CTRL: pri_ctrl <= w_byte;
            IDX_SEC_CTRL: sec_ctrl <= w_byte;
            IDX_PRI_PER_LO: pri_per[7:0] <= w_byte;
            IDX_PRI_PER_HI: pri_per[15:8] <= w_byte;
            IDX_SEC_PER_LO: sec_per[7:0] <= w_byte;
            IDX_SEC_PER_HI: sec_per[15:8] <= w_byte;
            IDX_LOOP_BW: loop_bw <= w_byte;
            IDX_LEG_SEL: leg_sel <= w_byte[4:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end
      else if (arready && axil_req_i.arvalid)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         case (axil_req_i.araddr[15:2])
            IDX_THR_LO: rdata <= {24'h000000, thr[7:0]};
            IDX_THR_HI: rdata <= {24'h000000, thr[15:8]};
            IDX_FILL: rdata <= {24'h000000, fill};
            IDX_DRAIN: rdata <= {24'h000000, drain};
            IDX_STAB_LO: rdata <= {24'h000000, stab_ms[7:0]};
            IDX_STAB_HI: rdata <= {24'h000000, stab_ms[15:8]};
            IDX_PRI_CTRL: rdata <= {24'h000000, pri_ctrl};
            IDX_SEC_CTRL: rdata <= {24'h000000, sec_ctrl};
            IDX_STATUS: rdata <= {24'h000000, status_byte};
            IDX_PRI_PER_LO: rdata <= {24'h000000, pri_per[7:0]};
            IDX_PRI_PER_HI: rdata <= {24'h000000, pri_per[15:8]};
            IDX_SEC_PER_LO: rdata <= {24'h000000, sec_per[7:0]};
            IDX_SEC_PER_HI: rdata <= {24'h000000, sec_per[15:8]};
            IDX_LOOP_BW: rdata <= {24'h000000, loop_bw};
            IDX_LEG_SEL: rdata <= {27'h0000000, leg_sel};
            IDX_LEG_STATUS: rdata <= {24'h000000, leg_status};
            default:
            begin
               rdata <= 32'h0000_0000;
               rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && axil_req_i.rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   assign axil_rsp_o = '{awready: awready, wready: wready, bresp: bresp, bvalid: bvalid,
                         arready: arready, rdata: rdata, rresp: rresp, rvalid: rvalid};

   // ----------------------------------------
   // Reference monitors
   // ----------------------------------------
   logic pri_nondef;
   logic [1:0] en;
   logic [1:0] ev;
   logic [15:0] exp_per [2];
   logic [17:0] cnt [2];
   logic [1:0] seen;
   logic [1:0] raw_vld;
   logic [4:0] pri_src;

   // Nondefault primary settings displace the legacy select
   assign pri_nondef = (pri_ctrl != CTRL_RST);
   assign pri_src = pri_nondef ? pri_ctrl[4:0] : leg_sel;
   assign en[0] = pri_ctrl[CTRL_EN_BIT] && !(pri_nondef && slot_null(pri_ctrl));
   assign en[1] = sec_ctrl[CTRL_EN_BIT] && !slot_null(sec_ctrl);
   assign ev[0] = ts_event_i[pri_src];
   assign ev[1] = ts_event_i[sec_ctrl[4:0]];
   assign exp_per[0] = pri_per;
   assign exp_per[1] = sec_per;

   // Cycle count between stamps; measured on each stamp
   for (genvar g = 0; g < 2; g++)
   begin : g_mon
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            cnt[g] <= 18'h00000;
            seen[g] <= 1'b0;
            raw_vld[g] <= 1'b0;
         end
         else if (!en[g])
         begin
            cnt[g] <= 18'h00000;
            seen[g] <= 1'b0;
            raw_vld[g] <= 1'b0;
         end
         else if (ev[g])
         begin
            cnt[g] <= 18'h00001;
            seen[g] <= 1'b1;
            raw_vld[g] <= seen[g] && period_ok(cnt[g], exp_per[g]);
         end
         else
         begin
            if (cnt[g] != 18'h3FFFF)
            begin
               cnt[g] <= cnt[g] + 18'h00001;
            end
            if (cnt[g] >= {1'b0, exp_per[g], 1'b0})
            begin
               raw_vld[g] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Millisecond tick, shared by both timers
   // ----------------------------------------
   logic [31:0] tick_cnt;
   logic ms_tick;
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tick_cnt <= 32'h0000_0000;
         ms_tick <= 1'b0;
      end
      else if (tick_cnt == 32'(MS_TICK_CYCLES - 1))
      begin
         tick_cnt <= 32'h0000_0000;
         ms_tick <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         ms_tick <= 1'b0;
      end
   end

   // Secondary validation delay, waived while primary is valid
   logic [15:0] val_ms;
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         val_ms <= 16'h0000;
      end
      else if (!raw_vld[1])
      begin
         val_ms <= 16'h0000;
      end
      // Validated beside a valid primary: stays valid when primary drops
      else if (raw_vld[0])
      begin
         val_ms <= VAL_DELAY_MS;
      end
      else if (ms_tick && val_ms != VAL_DELAY_MS)
      begin
         val_ms <= val_ms + 16'h0001;
      end
   end

   assign vld[0] = raw_vld[0];
   assign vld[1] = raw_vld[1] && (raw_vld[0] || val_ms == VAL_DELAY_MS);

   // ----------------------------------------
   // Switchover controller
   // ----------------------------------------
   ccl_sw_state_t next_sw_state;
   always_comb
   begin
      next_sw_state = sw_state;
      case (sw_state)
         SW_IDLE:
         begin
            if (vld[0])
            begin
               next_sw_state = SW_PRI;
            end
            else if (vld[1])
            begin
               next_sw_state = SW_SEC;
            end
         end
         // Held until invalid: no return to primary
         SW_PRI: if (!vld[0]) next_sw_state = vld[1] ? SW_SEC : SW_IDLE;
         SW_SEC: if (!vld[1]) next_sw_state = vld[0] ? SW_PRI : SW_IDLE;
         default: next_sw_state = SW_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sw_state <= SW_IDLE;
      end
      else
      begin
         sw_state <= next_sw_state;
      end
   end

   // ----------------------------------------
   // Programmable lock detector
   // ----------------------------------------
   logic prog_en;
   logic [16:0] acc;
   logic [16:0] acc_up;
   assign prog_en = (thr != 16'h0000);
   assign acc_up = acc + {9'h000, fill};

   // Saturating fill and drain; lock at top, unlock at zero
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         acc <= 17'h00000;
         pd_lock <= 1'b0;
      end
      else if (!prog_en || sw_state == SW_IDLE)
      begin
         acc <= 17'h00000;
         pd_lock <= 1'b0;
      end
      else if (phase_err_valid_i)
      begin
         if (phase_err_i <= thr)
         begin
            acc <= (acc_up >= {1'b0, LOCK_ACC_MAX}) ? {1'b0, LOCK_ACC_MAX} : acc_up;
            if (acc_up >= {1'b0, LOCK_ACC_MAX})
            begin
               pd_lock <= 1'b1;
            end
         end
         else
         begin
            acc <= (acc <= {9'h000, drain}) ? 17'h00000 : acc - {9'h000, drain};
            if (acc <= {9'h000, drain})
            begin
               pd_lock <= 1'b0;
            end
         end
      end
   end

   // Stability timer: programmable lock shown only after the programmed quiet time; legacy lock passes straight
   logic [15:0] stab_cnt;
   logic pd_lock_d;
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stab_cnt <= 16'h0000;
         pd_lock_d <= 1'b0;
         locked <= 1'b0;
      end
      else
      begin
         pd_lock_d <= pd_lock;
         if (!prog_en)
         begin
            locked <= legacy_lock_i && sw_state != SW_IDLE;
         end
         else if (!pd_lock)
         begin
            locked <= 1'b0;
         end
         else if (stab_ms == 16'h0000)
         begin
            locked <= 1'b1;
         end
         else if (!pd_lock_d)
         begin
            stab_cnt <= 16'h0000;
         end
         else if (ms_tick && !locked)
         begin
            stab_cnt <= stab_cnt + 16'h0001;
            if (stab_cnt + 16'h0001 >= stab_ms)
            begin
               locked <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Status and outputs
   // ----------------------------------------
   // Legacy reference bit is undefined here and reads zero
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[ST_ACTIVE_BIT] = loop_active_o;
      status_byte[ST_LOCK_BIT] = locked_o;
      status_byte[ST_ACT_REF_BIT] = (sw_state == SW_SEC);
      status_byte[ST_V0_BIT] = ref_valid_o[0];
      status_byte[ST_V1_BIT] = ref_valid_o[1];
      leg_status = 8'h00;
      leg_status[ST_LOCK_BIT] = locked_o;
      leg_status[ST_LEG_REF_BIT] = 1'b0;
   end

   // All outputs registered; events compare with registered validity
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ref_valid_o <= 2'b00;
         ref_event_o <= 4'h0;
         loop_active_o <= 1'b0;
         locked_o <= 1'b0;
         ref_src_sel_o <= 5'h00;
         loop_bw_o <= BW_RST;
      end
      else
      begin
         ref_valid_o <= vld;
         ref_event_o <= {ref_valid_o[1] & ~vld[1], ~ref_valid_o[1] & vld[1],
                         ref_valid_o[0] & ~vld[0], ~ref_valid_o[0] & vld[0]};
         loop_active_o <= (sw_state != SW_IDLE);
         locked_o <= locked;
         ref_src_sel_o <= (sw_state == SW_SEC) ? sec_ctrl[4:0] : pri_src;
         loop_bw_o <= loop_bw;
      end
   end

endmodule : ccl_ref_lock

// ==== ccl_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ccl_sva
   import ccl_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire ccl_pkg::ccl_axil_req_t axil_req_i,
   input wire ccl_pkg::ccl_axil_rsp_t axil_rsp_o,
   input wire logic [31:0] ts_event_i,
   input wire logic loop_active_o,
   input wire logic locked_o,
   input wire logic [1:0] ref_valid_o,
   input wire logic [3:0] ref_event_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   // Handshakes that launch a bus answer
   sequence s_ar_take;
      axil_req_i.arvalid && axil_rsp_o.arready;
   endsequence
   sequence s_wr_take;
      axil_req_i.awvalid && axil_rsp_o.awready && axil_req_i.wvalid && axil_rsp_o.wready;
   endsequence

   a_read_answer:
      assert property (s_ar_take |=> axil_rsp_o.rvalid) else $error("read answer late");
   a_write_answer:
      assert property (s_wr_take |-> ##2 axil_rsp_o.bvalid) else $error("write answer late");
   a_write_closed:
      assert property (axil_rsp_o.bvalid |-> !axil_rsp_o.awready && !axil_rsp_o.wready) else $error("write reopened");
   a_read_once:
      assert property (axil_rsp_o.rvalid && axil_req_i.rready |=> !axil_rsp_o.rvalid && axil_rsp_o.arready)
      else $error("read answer repeated");
   a_pri_rise_evt:
      assert property ($rose(ref_valid_o[0]) |-> ref_event_o[0]) else $error("primary valid event missing");
   a_pri_fall_evt:
      assert property ($fell(ref_valid_o[0]) |-> ref_event_o[1]) else $error("primary invalid event missing");
   a_sec_evts:
      assert property (ref_event_o[3:2] == {$fell(ref_valid_o[1]), $rose(ref_valid_o[1])})
      else $error("secondary events wrong");
   a_evt_single:
      assert property (ref_event_o != 4'h0 |=> (ref_event_o & $past(ref_event_o)) == 4'h0)
      else $error("event longer than one cycle");
   a_pri_on_stamp:
      assert property ($rose(ref_valid_o[0]) |-> $past(|ts_event_i, 1) || $past(|ts_event_i, 2)
         || $past(|ts_event_i, 3)) else $error("primary valid without stamp");
   a_lock_drop:
      assert property ($fell(loop_active_o) |-> ##[0:2] !locked_o) else $error("lock kept while idle");
endmodule : ccl_sva

bind ccl_ref_lock ccl_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .axil_req_i(axil_req_i),
   .axil_rsp_o(axil_rsp_o), .ts_event_i(ts_event_i), .loop_active_o(loop_active_o),
   .locked_o(locked_o), .ref_valid_o(ref_valid_o), .ref_event_o(ref_event_o));

// ==== ccl_ts_src.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Time stamp source model
// ----------------------------------------
module ccl_ts_src (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [4:0] src_i,
   input wire logic [15:0] period_i,
   output logic [31:0] ts_o
);
   logic [15:0] cnt;

   // One-cycle stamp per period; stopping restarts the phase
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt <= 16'h0000;
         ts_o <= 32'h0000_0000;
      end
      else
      begin
         ts_o <= 32'h0000_0000;
         if (!run_i)
            cnt <= 16'h0000;
         else if (cnt >= period_i - 16'h0001)
         begin
            cnt <= 16'h0000;
            ts_o[src_i] <= 1'b1;
         end
         else
            cnt <= cnt + 16'h0001;
      end
   end
endmodule : ccl_ts_src

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import ccl_pkg::*;
   localparam logic [13:0] RW_IDX [6] = '{IDX_THR_LO, IDX_THR_HI, IDX_FILL, IDX_DRAIN, IDX_STAB_LO, IDX_STAB_HI};
   logic clk_sys_i;
   logic rst_i;
   ccl_axil_req_t req;
   ccl_axil_rsp_t rsp;
   logic [31:0] ts_a;
   logic [31:0] ts_b;
   logic run_a;
   logic run_b;
   logic [15:0] phase_err;
   logic pe_valid;
   logic leg_lock;
   logic [4:0] src_sel;
   logic act;
   logic lock;
   logic [1:0] vld;
   logic [7:0] bw;
   int fails;
   int cmp_count;

   // ----------------------------------------
   // Clock, design and stamp sources
   // ----------------------------------------
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Short millisecond keeps the timers within a brief run
   ccl_ref_lock #(.MS_TICK_CYCLES(100)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .axil_req_i(req),
      .axil_rsp_o(rsp), .ts_event_i(ts_a | ts_b), .phase_err_i(phase_err), .phase_err_valid_i(pe_valid),
      .legacy_lock_i(leg_lock), .ref_src_sel_o(src_sel), .loop_active_o(act), .locked_o(lock),
      .ref_valid_o(vld), .ref_event_o(), .loop_bw_o(bw));
   ccl_ts_src u_src_a (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run_a), .src_i(5'h03),
      .period_i(16'h0100), .ts_o(ts_a));
   ccl_ts_src u_src_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run_b), .src_i(5'h05),
      .period_i(16'h0100), .ts_o(ts_b));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Address and data offered together, each released once taken
   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      @(posedge clk_sys_i);
      req.awaddr <= {idx, 2'b00};
      req.awvalid <= 1'b1;
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         if (rsp.awready)
            req.awvalid <= 1'b0;
         if (rsp.wready)
            req.wvalid <= 1'b0;
      end
      while (!rsp.bvalid);
      req.bready <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp, input logic [1:0] resp);
      @(posedge clk_sys_i);
      req.araddr <= {idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         if (rsp.arready)
            req.arvalid <= 1'b0;
      end
      while (!rsp.rvalid);
      req.rready <= 1'b0;
      chk($sformatf("reg %h", idx), {24'h000000, exp}, rsp.rdata);
      chk($sformatf("resp %h", idx), {30'h0, resp}, {30'h0, rsp.rresp});
   endtask : rd_chk

   // Which: 0 primary valid, 1 secondary valid, 2 lock
   task automatic wait_bit(input int which, input logic v, input int lim);
      int n;
      n = 0;
      while (((which == 2) ? lock : vld[which]) !== v && n < lim)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      chk($sformatf("flag %0d", which), {31'h0, v}, {31'h0, (which == 2) ? lock : vld[which]});
   endtask : wait_bit

   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      fails = 0;
      cmp_count = 0;
      rst_i = 1'b1;
      req = '0;
      {run_a, run_b, pe_valid, leg_lock} = 4'h0;
      phase_err = 16'h0000;
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd_chk(IDX_PRI_CTRL, CTRL_RST, RESP_OKAY);
      rd_chk(IDX_SEC_CTRL, CTRL_RST, RESP_OKAY);
      wr(IDX_STATUS, 8'hFF);
      rd_chk(IDX_STATUS, 8'h00, RESP_OKAY);
      rd_chk(14'h0D60, 8'h00, RESP_SLVERR);
      for (int i = 0; i < 6; i++)
         wr(RW_IDX[i], 8'hA0 + 8'(i));
      for (int i = 0; i < 6; i++)
         rd_chk(RW_IDX[i], 8'hA0 + 8'(i), RESP_OKAY);
      for (int i = 0; i < 6; i++)
         wr(RW_IDX[i], 8'h00);
      wr(IDX_LOOP_BW, 8'h3C);
      repeat (2) @(posedge clk_sys_i);
      chk("loop_bw", 32'h3C, {24'h000000, bw});
      // Primary alone, fixed detector follows the legacy lock
      run_a <= 1'b1;
      leg_lock <= 1'b1;
      wr(IDX_PRI_CTRL, 8'h83);
      wait_bit(0, 1'b1, 1000);
      repeat (4) @(posedge clk_sys_i);
      chk("src_sel", 32'h3, {27'h0, src_sel});
      rd_chk(IDX_STATUS, 8'h13, RESP_OKAY);
      rd_chk(IDX_LEG_STATUS, 8'h02, RESP_OKAY);
      // Programmable detector: fill, drain, then stability delay
      leg_lock <= 1'b0;
      pe_valid <= 1'b1;
      phase_err <= 16'h0010;
      wr(IDX_FILL, 8'hFF);
      wr(IDX_DRAIN, 8'hFF);
      wr(IDX_THR_LO, 8'h40);
      repeat (8) @(posedge clk_sys_i);
      chk("early_lock", 32'h0, {31'h0, lock});
      wait_bit(2, 1'b1, 30);
      phase_err <= 16'h0100;
      wait_bit(2, 1'b0, 30);
      wr(IDX_STAB_LO, 8'h02);
      phase_err <= 16'h0010;
      repeat (60) @(posedge clk_sys_i);
      chk("held_lock", 32'h0, {31'h0, lock});
      wait_bit(2, 1'b1, 400);
      wr(IDX_THR_LO, 8'h00);
      // Secondary joins; primary keeps the loop until disabled, then secondary holds it after primary returns
      run_b <= 1'b1;
      wr(IDX_SEC_CTRL, 8'h85);
      wait_bit(1, 1'b1, 700);
      rd_chk(IDX_STATUS, 8'h31, RESP_OKAY);
      wr(IDX_PRI_CTRL, 8'h03);
      wait_bit(0, 1'b0, 4);
      repeat (4) @(posedge clk_sys_i);
      chk("src_sel", 32'h5, {27'h0, src_sel});
      rd_chk(IDX_STATUS, 8'h29, RESP_OKAY);
      wr(IDX_PRI_CTRL, 8'h83);
      wait_bit(0, 1'b1, 1000);
      rd_chk(IDX_STATUS, 8'h39, RESP_OKAY);
      // Silent secondary times out, loop returns to primary
      run_b <= 1'b0;
      wait_bit(1, 1'b0, 600);
      repeat (4) @(posedge clk_sys_i);
      rd_chk(IDX_STATUS, 8'h11, RESP_OKAY);
      // Secondary alone must wait out its validation delay
      wr(IDX_PRI_CTRL, 8'h03);
      run_b <= 1'b1;
      repeat (700) @(posedge clk_sys_i);
      chk("sec_early", 32'h0, {31'h0, vld[1]});
      wait_bit(1, 1'b1, 1200);
      repeat (4) @(posedge clk_sys_i);
      rd_chk(IDX_STATUS, 8'h21 | 8'h08, RESP_OKAY);
      close_out();
   end

   // Hang guard, far beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      close_out();
   end
endmodule : tb_top
